// [logic/ais_pkg.sv]
// Constants and types for the converter input selection and test mode block.
package ais_pkg;

    // ========================================
    // Register addressing
    localparam logic [1:0] AIS_ADDR_MODE = 2'h0;
    localparam logic [1:0] AIS_ADDR_SYS = 2'h1;
    localparam int AIS_REG_W = 10;

    // ========================================
    // Mode control field positions
    localparam int AIS_MODE_VREF_BIT = 0;
    localparam int AIS_MODE_PD_BIT = 2;
    localparam int AIS_MODE_PICK_LO = 3;
    localparam int AIS_MODE_DIFF_LO = 5;
    localparam int AIS_MODE_SCAN_BIT = 7;
    localparam int AIS_MODE_TEST_LO = 8;

    // ========================================
    // System control field positions
    localparam int AIS_SYS_RESET_BIT = 0;
    localparam int AIS_SYS_SYNC_BIT = 1;
    localparam int AIS_SYS_STROBE_BIT = 6;
    localparam int AIS_SYS_FORMAT_BIT = 7;
    localparam int AIS_SYS_OFFSET_BIT = 8;

    // ========================================
    // Reset values
    localparam logic [9:0] AIS_MODE_RESET = 10'h020;
    localparam logic [9:0] AIS_SYS_RESET = 10'h030;

    // ========================================
    // Analog source codes driven to the multiplexer
    typedef enum logic [2:0] {
        AIS_SRC_A_POS = 3'h0,
        AIS_SRC_A_NEG = 3'h1,
        AIS_SRC_B_POS = 3'h2,
        AIS_SRC_B_NEG = 3'h3,
        AIS_SRC_A_DIFF = 3'h4,
        AIS_SRC_B_DIFF = 3'h5,
        AIS_SRC_NONE = 3'h7
    } ais_src_t;

    typedef enum logic [1:0] {
        AIS_TEST_NORMAL = 2'h0,
        AIS_TEST_REF_POS = 2'h1,
        AIS_TEST_REF_MID = 2'h2,
        AIS_TEST_REF_NEG = 2'h3
    } ais_test_t;

    localparam logic [1:0] AIS_STEP_FIRST = 2'h0;

endpackage

// [logic/ais_seq_table.sv]
// Lookup of the analog source for one step of the selected scan sequence.
`timescale 1ns/100ps
module ais_seq_table
    import ais_pkg::*;
(
    // Selection
    input wire logic [4:0] i_sel,
    input wire logic [1:0] i_step,
    // Result
    output ais_src_t o_src,
    output logic [1:0] o_last,
    output logic o_valid
);

    always_comb begin
        o_src = AIS_SRC_NONE;
        o_last = 2'h0;
        o_valid = 1'b1;
        // Selection is {scan, diff_count_high, diff_count_low, input_pick}.
        case (i_sel)
            5'h00: o_src = AIS_SRC_A_POS; // [R4]
            5'h01: o_src = AIS_SRC_A_NEG; // [R4]
            5'h02: o_src = AIS_SRC_B_POS; // [R4]
            5'h03: o_src = AIS_SRC_B_NEG; // [R4]
            5'h04: o_src = AIS_SRC_A_DIFF; // [R5]
            5'h05: o_src = AIS_SRC_B_DIFF; // [R5]
            5'h11: begin
                o_last = 2'h1; // [R6]
                o_src = (i_step == 2'h0) ? AIS_SRC_A_POS : AIS_SRC_A_NEG;
            end
            5'h12: begin
                o_last = 2'h2; // [R7]
                o_src = ais_src_t'({1'b0, i_step});
            end
            5'h13: begin
                o_last = 2'h3; // [R8]
                o_src = ais_src_t'({1'b0, i_step});
            end
            5'h15: begin
                o_last = 2'h1; // [R9]
                o_src = (i_step == 2'h0) ? AIS_SRC_A_POS : AIS_SRC_B_DIFF;
            end
            5'h16: begin
                o_last = 2'h2; // [R10]
                case (i_step)
                    2'h0: o_src = AIS_SRC_A_POS;
                    2'h1: o_src = AIS_SRC_A_NEG;
                    default: o_src = AIS_SRC_B_DIFF;
                endcase
            end
            5'h19: begin
                o_last = 2'h1; // [R11]
                o_src = (i_step == 2'h0) ? AIS_SRC_A_DIFF : AIS_SRC_B_DIFF;
            end
            default: o_valid = 1'b0; // [R12]
        endcase
    end

endmodule // ais_seq_table

// [logic/ais_input_select.sv]
// Control registers, input selection, autoscan sequencing and test source choice.
`timescale 1ns/100ps
// Contract
// R1: Bits 3 and 4 pick input or pair.
// R2: Bit 5 picks single-ended or differential.
// R3: Bits 6 and 7 enable and shape autoscan.
// R4: Plain codes pick single inputs A+,A-,B+,B-.
// R5: Low input pick bit picks A or B pair.
// R6: Scan code 01 alternates A+ and A-.
// R7: Scan code 10 cycles A+, A-, B+.
// R8: Scan code 11 cycles all four inputs.
// R9: Scan diff 01 code 01: A+, B pair.
// R10: Scan diff 01 code 10: A+, A-, B pair.
// R11: Scan diff 10 code 01: A pair, B pair.
// R12: Host writes no reserved selection codes.
// R13: Bits 8 and 9 select test mode.
// R14: Test codes give normal, ref+, midpoint, ref-.
// R15: System register bit layout, write only.
// R16: Address 00 mode, 01 system, others reserved.
// R17: Mode reset value has low diff bit set.
// R18: Scan advances once per conversion, wrapping.
module ais_input_select
    import ais_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Register write port
    input wire logic i_wr,
    input wire logic [1:0] i_reg_addr,
    input wire logic [AIS_REG_W-1:0] i_wdata,
    // Conversion pacing, one pulse per conversion
    input wire logic i_conv_done,
    // Selection outputs
    output ais_src_t o_src,
    output ais_test_t o_test,
    output logic o_sel_reserved,
    output logic [1:0] o_scan_step,
    // Other mode controls
    output logic o_ext_ref,
    output logic o_power_down,
    // System controls
    output logic o_device_reset,
    output logic o_sync_gen_reset,
    output logic o_strobe_style,
    output logic o_output_format_sel,
    output logic o_offset_cal
);

    // ========================================
    // Register state
    logic [AIS_REG_W-1:0] adc_mode_control;
    logic [AIS_REG_W-1:0] adc_system_control;
    logic [1:0] step;
    logic [AIS_REG_W-1:0] next_mode;
    logic [AIS_REG_W-1:0] next_sys;
    logic [1:0] next_step;
    logic [4:0] sel;
    logic [1:0] last_step;

    // ========================================
    // Decoded fields and write strobes
    logic [1:0] input_pick;
    logic [1:0] diff_count;
    logic scan_on;
    logic device_hold;
    logic mode_wr;
    logic sys_wr;
    logic sys_reset_wr;
    logic step_wrap;
    logic [4:0] next_sel;
    ais_src_t next_tbl_src;
    logic next_sel_valid;

    // ========================================
    // Output register state
    ais_src_t shown_src;
    logic shown_reserved;
    ais_test_t shown_test;
    ais_src_t next_shown_src;
    logic next_shown_reserved;
    ais_test_t next_shown_test;

    // ========================================
    // Field decode
    assign input_pick = adc_mode_control[AIS_MODE_PICK_LO +: 2]; // [R1]
    assign diff_count = adc_mode_control[AIS_MODE_DIFF_LO +: 2]; // [R2] [R3]
    assign scan_on = adc_mode_control[AIS_MODE_SCAN_BIT]; // [R3]
    // The device reset bit of the system register freezes the mode register.
    assign device_hold = adc_system_control[AIS_SYS_RESET_BIT]; // [R15]

    // Selection is {scan, diff_count_high, diff_count_low, input_pick_high, input_pick_low}.
    assign sel = {scan_on, diff_count, input_pick}; // [R1] [R2] [R3]

    // ========================================
    // Write decode
    // Mode writes are refused while the device reset bit holds the mode register.
    assign mode_wr = i_wr && (i_reg_addr == AIS_ADDR_MODE) && !device_hold; // [R16]
    assign sys_wr = i_wr && (i_reg_addr == AIS_ADDR_SYS); // [R16]
    assign sys_reset_wr = sys_wr && i_wdata[AIS_SYS_RESET_BIT]; // [R15]

    // A selection without scan has one step, so it wraps on every conversion.
    assign step_wrap = !scan_on || (step >= last_step); // [R18]

    // ========================================
    // Sequence tables
    // The current selection tells where its sequence ends.
    ais_seq_table u_table (
        .i_sel(sel),
        .i_step(step),
        .o_src(),
        .o_last(last_step),
        .o_valid()
    );

    // The source output is registered from the next selection and step, so it changes
    // on the same edge as the mode register and the step, with no comb path to the pin.
    assign next_sel = {next_mode[AIS_MODE_SCAN_BIT], next_mode[AIS_MODE_DIFF_LO +: 2],
        next_mode[AIS_MODE_PICK_LO +: 2]};

    ais_seq_table u_next_table (
        .i_sel(next_sel),
        .i_step(next_step),
        .o_src(next_tbl_src),
        .o_last(),
        .o_valid(next_sel_valid)
    );

    // ========================================
    // Control register group
    always_comb begin
        next_mode = adc_mode_control;
        next_sys = adc_system_control;
        if (device_hold) begin
            // Device reset holds the mode register at its reset value until cleared.
            next_mode = AIS_MODE_RESET; // [R17]
        end
        if (mode_wr) begin
            next_mode = i_wdata; // [R16]
        end
        if (sys_wr) begin
            next_sys = i_wdata; // [R15] [R16]
        end
        if (sys_reset_wr) begin
            // Both registers return to reset values; the reset bit stays set until cleared.
            next_mode = AIS_MODE_RESET; // [R17]
            next_sys = AIS_SYS_RESET | (AIS_REG_W'(1) << AIS_SYS_RESET_BIT); // [R15]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            adc_mode_control <= AIS_MODE_RESET; // [R17]
            adc_system_control <= AIS_SYS_RESET;
        end else begin
            adc_mode_control <= next_mode;
            adc_system_control <= next_sys;
        end
    end

    // ========================================
    // Scan step group
    always_comb begin
        next_step = step;
        // A write to the mode register wins over a conversion in the same cycle.
        if (device_hold || mode_wr || sys_reset_wr) begin
            // A new or held selection starts from the first step of its sequence.
            next_step = AIS_STEP_FIRST;
        end else if (i_conv_done) begin
            if (step_wrap) begin
                next_step = AIS_STEP_FIRST; // [R18]
            end else begin
                next_step = step + 2'h1; // [R18]
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            step <= AIS_STEP_FIRST;
        end else begin
            step <= next_step;
        end
    end

    // ========================================
    // Output register group
    always_comb begin
        // A reserved selection shows no source and raises the flag.
        next_shown_src = next_tbl_src; // [R4] [R5] [R6] [R7] [R8] [R9] [R10] [R11]
        next_shown_reserved = !next_sel_valid;
        next_shown_test = ais_test_t'(next_mode[AIS_MODE_TEST_LO +: 2]); // [R13] [R14]
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            // The mode reset value picks the A pair with normal conversion.
            shown_src <= AIS_SRC_A_DIFF; // [R17]
            shown_reserved <= 1'b0;
            shown_test <= AIS_TEST_NORMAL;
        end else begin
            shown_src <= next_shown_src;
            shown_reserved <= next_shown_reserved;
            shown_test <= next_shown_test;
        end
    end

    // ========================================
    // Outputs
    assign o_src = shown_src;
    assign o_sel_reserved = shown_reserved;
    assign o_scan_step = step;
    assign o_test = shown_test;
    // Reference and power-down bits pass straight from the mode register.
    assign o_ext_ref = adc_mode_control[AIS_MODE_VREF_BIT];
    assign o_power_down = adc_mode_control[AIS_MODE_PD_BIT];
    assign o_device_reset = adc_system_control[AIS_SYS_RESET_BIT]; // [R15]
    assign o_sync_gen_reset = adc_system_control[AIS_SYS_SYNC_BIT]; // [R15]
    assign o_strobe_style = adc_system_control[AIS_SYS_STROBE_BIT]; // [R15]
    assign o_output_format_sel = adc_system_control[AIS_SYS_FORMAT_BIT]; // [R15]
    assign o_offset_cal = adc_system_control[AIS_SYS_OFFSET_BIT]; // [R15]

endmodule // ais_input_select

// [tb/ais_chk.sv]
// Assertion checker for the input selection block.
`timescale 1ns/100ps
module ais_chk
    import ais_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr,
    input wire logic [1:0] i_reg_addr,
    input wire logic [AIS_REG_W-1:0] i_wdata,
    input wire logic i_conv_done,
    input ais_src_t o_src,
    input ais_test_t o_test,
    input wire logic o_sel_reserved,
    input wire logic [1:0] o_scan_step,
    input wire logic o_device_reset,
    input wire logic o_sync_gen_reset,
    input wire logic o_offset_cal
);
    wire logic mw = i_wr && i_reg_addr == AIS_ADDR_MODE && !o_device_reset;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    reset_value_a: assert property ($past(i_sys_rst) |-> o_src == AIS_SRC_A_DIFF)
        else $error("mode not at reset value");
    test_follow_a: assert property (mw |=> o_test == $past(i_wdata[9:8]))
        else $error("test mode does not follow write");
    pick_single_a: assert property (mw && i_wdata[7:5] == 3'h0 |=>
        o_src == ais_src_t'({1'b0, $past(i_wdata[4:3])})) else $error("wrong single input");
    step_clear_a: assert property (mw |=> o_scan_step == 2'h0)
        else $error("mode write left step");
    step_adv_a: assert property (i_conv_done && !i_wr && o_scan_step != 2'h0
        |=> o_scan_step != $past(o_scan_step)) else $error("scan did not advance");
    step_hold_a: assert property (!i_conv_done && !i_wr |=> $stable(o_scan_step))
        else $error("step moved without conversion");
    sys_write_a: assert property (i_wr && i_reg_addr == AIS_ADDR_SYS && !i_wdata[0] |=>
        {o_offset_cal, o_sync_gen_reset, o_device_reset} == {$past(i_wdata[8]),
        $past(i_wdata[1:0])}) else $error("system bits wrong");
    sys_reset_a: assert property (i_wr && i_reg_addr == AIS_ADDR_SYS && i_wdata[0] |=>
        o_device_reset && !o_sync_gen_reset && !o_offset_cal) else $error("system reset wrong");
    dev_hold_a: assert property (o_device_reset |-> o_src == AIS_SRC_A_DIFF)
        else $error("mode not held in device reset");
    addr_ignore_a: assert property (i_wr && i_reg_addr[1] |=> $stable(o_test))
        else $error("reserved address took effect");
    resv_none_a: assert property (o_sel_reserved |-> o_src == AIS_SRC_NONE)
        else $error("reserved code gave a source");
    cover property (mw && i_wdata[7]);
    cover property (i_conv_done && o_scan_step == 2'h3);
    cover property (o_device_reset);
endmodule // ais_chk

// [tb/ais_host.sv]
// Host model that writes the control registers over the parallel bus.
`timescale 1ns/100ps
module ais_host (
    input wire logic i_clk,
    output logic o_wr = 1'b0,
    output logic [1:0] o_reg_addr = 2'h0,
    output logic [9:0] o_wdata = 10'h000
);
    // One write per call; the data lines show the inverse once released.
    task automatic wr(input logic [1:0] a, input logic [9:0] d);
        @(negedge i_clk);
        o_reg_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask
endmodule // ais_host

// [tb/testbench.sv]
// Self-checking testbench for the input selection block.
`timescale 1ns/100ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
    $display("unexpected %s: expected %0h, seen %0h", nm, e, s); end end
module testbench;
    import ais_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_conv_done = 1'b0;
    logic i_wr;
    logic [1:0] i_reg_addr, o_scan_step;
    logic [9:0] i_wdata, d;
    ais_src_t o_src;
    ais_test_t o_test;
    logic o_sel_reserved, o_ext_ref, o_power_down, o_device_reset, o_sync_gen_reset;
    logic o_strobe_style, o_output_format_sel, o_offset_cal;
    int n_fail = 0;
    int num_checks = 0;
    int seed = 32'hC6E46906;
    always #10 i_clk = ~i_clk;
    ais_host ais_host_inst (.i_clk, .o_wr(i_wr), .o_reg_addr(i_reg_addr), .o_wdata(i_wdata));
    ais_input_select ais_input_select_inst (.i_clk, .i_sys_rst, .i_wr, .i_reg_addr, .i_wdata,
        .i_conv_done, .o_src, .o_test, .o_sel_reserved, .o_scan_step, .o_ext_ref,
        .o_power_down, .o_device_reset, .o_sync_gen_reset, .o_strobe_style,
        .o_output_format_sel, .o_offset_cal);
    function automatic ais_src_t exp_src(input logic [4:0] s, input int k);
        case (s)
            5'h00, 5'h01, 5'h02, 5'h03: return ais_src_t'({1'b0, s[1:0]});
            5'h04: return AIS_SRC_A_DIFF;
            5'h05: return AIS_SRC_B_DIFF;
            5'h11: return ais_src_t'(k % 2);
            5'h12: return ais_src_t'(k % 3);
            5'h13: return ais_src_t'(k % 4);
            5'h15: return (k % 2 == 1) ? AIS_SRC_B_DIFF : AIS_SRC_A_POS;
            5'h16: return (k % 3 == 2) ? AIS_SRC_B_DIFF : ais_src_t'(k % 3);
            5'h19: return (k % 2 == 1) ? AIS_SRC_B_DIFF : AIS_SRC_A_DIFF;
            default: return AIS_SRC_NONE;
        endcase
    endfunction
    task automatic pulse();
        @(negedge i_clk);
        i_conv_done = 1'b1;
        @(negedge i_clk);
        i_conv_done = 1'b0;
    endtask
    task automatic results();
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        results();
    end
    // ========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        `CHK("src", AIS_SRC_A_DIFF, o_src)
        `CHK("test", AIS_TEST_NORMAL, o_test)
        for (int s = 0; s < 32; s++) begin
            d = 10'($random(seed));
            d[7:3] = s[4:0];
            ais_host_inst.wr(AIS_ADDR_MODE, d);
            `CHK("test", ais_test_t'(d[9:8]), o_test)
            `CHK("ref", d[0], o_ext_ref)
            `CHK("pd", d[2], o_power_down)
            `CHK("resv", exp_src(s[4:0], 0) == AIS_SRC_NONE, o_sel_reserved)
            for (int k = 0; k < 6; k++) begin
                `CHK("src", exp_src(s[4:0], k), o_src)
                pulse();
            end
        end
        for (int a = 2; a < 4; a++) begin
            ais_host_inst.wr(a[1:0], 10'h3FF);
            `CHK("test", ais_test_t'(d[9:8]), o_test)
        end
        repeat (4) begin
            d = 10'($random(seed)) & 10'h1FE;
            ais_host_inst.wr(AIS_ADDR_SYS, d);
            `CHK("sys", {d[8:6], d[1]}, {o_offset_cal, o_output_format_sel, o_strobe_style,
                o_sync_gen_reset})
        end
        ais_host_inst.wr(AIS_ADDR_SYS, 10'h001);
        ais_host_inst.wr(AIS_ADDR_MODE, 10'h398);
        `CHK("src", AIS_SRC_A_DIFF, o_src)
        `CHK("dev", 1'b1, o_device_reset)
        ais_host_inst.wr(AIS_ADDR_SYS, 10'h000);
        ais_host_inst.wr(AIS_ADDR_MODE, 10'h098);
        `CHK("src", AIS_SRC_A_POS, o_src)
        pulse();
        pulse();
        `CHK("src", AIS_SRC_B_POS, o_src)
        `CHK("step", 2'h2, o_scan_step)
        // Reset in mid-scan returns the mode register and the step to their reset values.
        @(negedge i_clk);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        `CHK("src", AIS_SRC_A_DIFF, o_src)
        `CHK("step", 2'h0, o_scan_step)
        `CHK("test", AIS_TEST_NORMAL, o_test)
        results();
    end
endmodule // testbench
bind ais_input_select ais_chk ais_chk_inst (.i_clk, .i_sys_rst, .i_wr, .i_reg_addr, .i_wdata,
    .i_conv_done, .o_src, .o_test, .o_sel_reserved, .o_scan_step, .o_device_reset,
    .o_sync_gen_reset, .o_offset_cal);
